// >>> hw/gcr_pkg.sv
// constants for the gpio configuration and rail switch control block
package gcr_pkg;
	localparam logic [7:0] OFS_PINS_14_15_CONFIG   = 8'h1C;
	localparam logic [7:0] OFS_PINS_0_7_MODE_BITS  = 8'h1D;
	localparam logic [7:0] OFS_PINS_8_15_MODE_BITS = 8'h1E;
	localparam logic [7:0] OFS_RAIL_SWITCH_CONTROL = 8'h1F;
	localparam logic [7:0] OFS_WAKE_STATUS_LO      = 8'h30;
	localparam logic [7:0] OFS_WAKE_STATUS_HI      = 8'h31;
	localparam logic [7:0] OFS_WAKE_MASK_LO        = 8'h32;
	localparam logic [7:0] OFS_WAKE_MASK_HI        = 8'h33;
	localparam logic [7:0] OFS_PIN_ACTIVE_LO       = 8'h34;
	localparam logic [7:0] OFS_PIN_ACTIVE_HI       = 8'h35;
	localparam logic [7:0] OFS_SWITCH_STATE        = 8'h36;

	// pins_14_15_config fields
	localparam int POS_PIN15_WAKE_SUPPRESS   = 7;
	localparam int POS_PIN15_POLARITY_SUPPLY = 6;
	localparam int POS_PIN15_FUNCTION_SELECT = 4;
	localparam int POS_PIN14_WAKE_SUPPRESS   = 3;
	localparam int POS_PIN14_POLARITY_SUPPLY = 2;
	localparam int POS_PIN14_FUNCTION_SELECT = 0;
	// rail_switch_control fields
	localparam int POS_CHARGE_PUMP_AUTO      = 7;
	localparam int POS_CORE_SWITCH_INTERNAL  = 6;
	localparam int POS_SWITCH_CLOSE_SLEW     = 4;
	localparam int POS_PERIPHERAL_SWITCH_SEL = 2;
	localparam int POS_CORE_SWITCH_SEL       = 0;

	localparam logic [7:0]  RST_PINS_14_15_CONFIG = 8'h11;
	localparam logic [7:0]  RST_MODE_BITS         = 8'h00;
	localparam logic [7:0]  RST_RAIL_SWITCH       = 8'h00;
	localparam logic [15:0] RST_WAKE_MASK         = 16'h0000;

	typedef enum logic [1:0] {
		GCR_FN_OD_BLINK = 2'h0,
		GCR_FN_INPUT    = 2'h1,
		GCR_FN_TWO_WIRE = 2'h2,
		GCR_FN_MODE_OUT = 2'h3
	} gcr_func_t;

	typedef enum logic [1:0] {
		GCR_SEL_NONE   = 2'h0,
		GCR_SEL_PIN1   = 2'h1,
		GCR_SEL_PIN2   = 2'h2,
		GCR_SEL_PIN13  = 2'h3
	} gcr_sel_t;

	localparam int  CLK_PERIOD_NS      = 50;
	localparam int  DEBOUNCE_TIME_US   = 1000;
	localparam int  DEBOUNCE_CYCLES    = DEBOUNCE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int  CP_SETTLE_TIME_NS  = 2000;
	localparam int  CP_SETTLE_CYCLES   =
		(CP_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  DEB_CNT_W          = 16;
	localparam int  CP_CNT_W           = 8;
	// edges after reset until the pin pipeline shows real levels
	localparam int  WAKE_ARM_CYCLES    = 6;
endpackage

// >>> hw/gcr_top.sv
// gpio configuration, input debouncing, wake-up and rail switch control
// Functional notes
// RULE_01 - cleared wake bit: passive-to-active raises wake-up
// RULE_02 - type bit: input polarity and output supply
// RULE_03 - pin 15 function field decode
// RULE_04 - pin 14 function field decode
// RULE_05 - pin 14 type selects two-wire supply
// RULE_06 - input mode bit enables debouncing
// RULE_07 - mode-controlled output follows mode bit
// RULE_08 - sequencer outputs polarity from mode bit
// RULE_09 - blinking polarity inverted by mode bit
// RULE_10 - feedback output polarity from mode bit
// RULE_11 - supply-fault output polarity from mode bit
// RULE_12 - mode bit debounces enable inputs pins 8-10
// RULE_13 - charge pump static or auto operation
// RULE_14 - internal core switch from first core buck
// RULE_15 - closing slew rate select field
// RULE_16 - selected pin opens and closes peripheral switch
// RULE_17 - selected pin opens and closes core switch
// RULE_18 - selector decodes none, pin 1, 2, 13
// RULE_19 - detection uses polarity and debounced level
`timescale 1ns/1ps
module gcr_top
	import gcr_pkg::*;
#(
	parameter int DEB_CYCLES = gcr_pkg::DEBOUNCE_CYCLES
)(
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	output logic             IRQ_O,
	input  wire logic [15:0] GPIO_I,
	input  wire logic [13:0] PIN_ACTIVE_HIGH_I,
	input  wire logic [13:0] WAKE_SUPPRESS_I,
	input  wire logic        BLINK_I,
	input  wire logic        TW_SDA_LOW_I,
	input  wire logic        TW_SCL_LOW_I,
	input  wire logic [4:0]  SEQ_I,
	input  wire logic        FEEDBACK_I,
	input  wire logic        FAULT_I,
	output logic             PIN14_OUT_O,
	output logic             PIN14_OE_N_O,
	output logic             PIN15_OUT_O,
	output logic             PIN15_OE_N_O,
	output logic             PIN14_SUPPLY_O,
	output logic             PIN15_SUPPLY_O,
	output logic             TW_SUPPLY_O,
	output logic             TW_SDA_O,
	output logic             TW_SCL_O,
	output logic [4:0]       SEQ_PIN_O,
	output logic             FEEDBACK_PIN_O,
	output logic             FAULT_PIN_O,
	output logic             BLINK11_PIN_O,
	output logic             SYSTEM_ENABLE_INPUT_O,
	output logic             POWER_ENABLE_INPUT_O,
	output logic             POWER1_ENABLE_INPUT_O,
	output logic             CORE_RAIL_SWITCH_CLOSE_O,
	output logic             CORE_SWITCH_INTERNAL_CLOSE_O,
	output logic             PERIPHERAL_RAIL_SWITCH_CLOSE_O,
	output logic             CHARGE_PUMP_EN_O,
	output logic [1:0]       SWITCH_SLEW_O
);
	import gcr_pkg::*;

	logic [7:0]  cfg_q;
	logic [15:0] mode_q;
	logic [7:0]  rsw_q;
	logic [15:0] wake_st_q;
	logic [15:0] wake_mask_q;
	logic [15:0] wake_ev;
	logic [15:0] deb_lvl;
	logic [15:0] active;
	logic [15:0] active_q;
	logic [15:0] pol_high;
	logic [15:0] suppress;
	logic [15:0] is_input;
	logic [15:0] w1c;
	logic [1:0]  fn14;
	logic [1:0]  fn15;
	logic        pin14_lvl;
	logic        pin15_lvl;
	logic        pin14_oe_n;
	logic        pin15_oe_n;
	logic        core_act;
	logic        peri_act;
	logic        core_act_q;
	logic        peri_act_q;
	logic        core_req_q;
	logic        peri_req_q;
	logic        cp_on;
	logic        cp_ready;
	logic [CP_CNT_W-1:0] cp_cnt_q;
	logic [7:0]  rd_d;
	logic        wr_en;
	logic [2:0]  arm_q;
	logic        armed;

	assign wr_en = WR_I & CE_I;
	assign armed = (arm_q == 3'(WAKE_ARM_CYCLES));
	assign fn14  = cfg_q[POS_PIN14_FUNCTION_SELECT +: 2];
	assign fn15  = cfg_q[POS_PIN15_FUNCTION_SELECT +: 2];

	// register writes
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			cfg_q  <= RST_PINS_14_15_CONFIG;
			mode_q <= {RST_MODE_BITS, RST_MODE_BITS};
			rsw_q  <= RST_RAIL_SWITCH;
		end
		else if (wr_en)
		begin
			case (ADDR_I)
				OFS_PINS_14_15_CONFIG:   cfg_q        <= WDATA_I;
				OFS_PINS_0_7_MODE_BITS:  mode_q[7:0]  <= WDATA_I; // see RULE_06
				OFS_PINS_8_15_MODE_BITS: mode_q[15:8] <= WDATA_I; // see RULE_06
				OFS_RAIL_SWITCH_CONTROL: rsw_q        <= WDATA_I;
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			wake_mask_q <= RST_WAKE_MASK;
		else if (wr_en && ADDR_I == OFS_WAKE_MASK_LO)
			wake_mask_q[7:0] <= WDATA_I;
		else if (wr_en && ADDR_I == OFS_WAKE_MASK_HI)
			wake_mask_q[15:8] <= WDATA_I;
	end

	// read data stands one cycle after the strobe
	always_comb
	begin
		case (ADDR_I)
			OFS_PINS_14_15_CONFIG:   rd_d = cfg_q;
			OFS_PINS_0_7_MODE_BITS:  rd_d = mode_q[7:0];
			OFS_PINS_8_15_MODE_BITS: rd_d = mode_q[15:8];
			OFS_RAIL_SWITCH_CONTROL: rd_d = rsw_q;
			OFS_WAKE_STATUS_LO:      rd_d = wake_st_q[7:0];
			OFS_WAKE_STATUS_HI:      rd_d = wake_st_q[15:8];
			OFS_WAKE_MASK_LO:        rd_d = wake_mask_q[7:0];
			OFS_WAKE_MASK_HI:        rd_d = wake_mask_q[15:8];
			OFS_PIN_ACTIVE_LO:       rd_d = active_q[7:0];
			OFS_PIN_ACTIVE_HI:       rd_d = active_q[15:8];
			OFS_SWITCH_STATE:
				rd_d = {5'h00, CHARGE_PUMP_EN_O, peri_req_q, core_req_q};
			default:                 rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			RDATA_O <= 8'h00;
		else if (CE_I)
			RDATA_O <= RD_I ? rd_d : 8'h00;
	end

	// per-pin polarity, wake suppression and input qualification
	assign pol_high = {cfg_q[POS_PIN15_POLARITY_SUPPLY],
		cfg_q[POS_PIN14_POLARITY_SUPPLY], PIN_ACTIVE_HIGH_I}; // see RULE_02
	assign suppress = {cfg_q[POS_PIN15_WAKE_SUPPRESS],
		cfg_q[POS_PIN14_WAKE_SUPPRESS], WAKE_SUPPRESS_I};
	assign is_input = {fn15 == GCR_FN_INPUT, fn14 == GCR_FN_INPUT, 14'h3FFF};

	// three-stage sampling and debounce, one instance per pin
	for (genvar i = 0; i < 16; i++)
	begin : g_pin
		logic [2:0]           sync_q;
		logic                 filt_q;
		logic                 deb_q;
		logic [DEB_CNT_W-1:0] cnt_q;

		always_ff @(posedge REF_CLK_I)
		begin
			if (!RST_N_I)
				sync_q <= 3'h0;
			else if (CE_I)
				sync_q <= {sync_q[1:0], GPIO_I[i]};
		end

		// a change counts only once the last two stages agree
		always_ff @(posedge REF_CLK_I)
		begin
			if (!RST_N_I)
				filt_q <= 1'b0;
			else if (CE_I && sync_q[1] == sync_q[2])
				filt_q <= sync_q[2];
		end

		// mode bit set: the level must hold for the full debounce time
		always_ff @(posedge REF_CLK_I)
		begin
			if (!RST_N_I)
			begin
				deb_q <= 1'b0;
				cnt_q <= '0;
			end
			else if (CE_I)
			begin
				if (!mode_q[i] || filt_q == deb_q) // see RULE_06, RULE_12
				begin
					deb_q <= filt_q;
					cnt_q <= '0;
				end
				else if (cnt_q >= DEB_CNT_W'(DEB_CYCLES - 1))
				begin
					deb_q <= filt_q;
					cnt_q <= '0;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end

		assign deb_lvl[i] = deb_q;
		assign active[i]  = deb_lvl[i] ^ ~pol_high[i]; // see RULE_19
		assign wake_ev[i] = CE_I & armed & is_input[i] & ~suppress[i] &
			active[i] & ~active_q[i]; // see RULE_01
		assign w1c[i] = wr_en & WDATA_I[i % 8] &
			(ADDR_I == ((i < 8) ? OFS_WAKE_STATUS_LO : OFS_WAKE_STATUS_HI));
	end

	// reset levels are not pin levels: no wake edge until the
	// sampling and debounce stages have been refilled
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			arm_q <= 3'h0;
		else if (CE_I && !armed)
			arm_q <= arm_q + 3'h1;
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			active_q <= 16'h0000;
		else if (CE_I)
			active_q <= active;
	end

	// a wake edge in the clearing cycle survives the clear
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			wake_st_q <= 16'h0000;
		else
			wake_st_q <= (wake_st_q & ~w1c) | wake_ev; // see RULE_01
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			IRQ_O <= 1'b0;
		else if (CE_I)
			IRQ_O <= |(wake_st_q & wake_mask_q);
	end

	// pins 14 and 15: level wanted on the pin, and whether it is driven
	always_comb
	begin
		pin14_lvl  = 1'b1;
		pin14_oe_n = 1'b1;
		case (fn14) // see RULE_04
			GCR_FN_OD_BLINK:
			begin
				pin14_lvl  = BLINK_I ^ mode_q[14]; // see RULE_09
				pin14_oe_n = pin14_lvl;
			end
			GCR_FN_TWO_WIRE:
			begin
				pin14_lvl  = ~TW_SDA_LOW_I;
				pin14_oe_n = ~TW_SDA_LOW_I;
			end
			GCR_FN_MODE_OUT:
			begin
				pin14_lvl  = mode_q[14]; // see RULE_07
				pin14_oe_n = 1'b0;
			end
			default: ;
		endcase
	end

	always_comb
	begin
		pin15_lvl  = 1'b1;
		pin15_oe_n = 1'b1;
		case (fn15) // see RULE_03
			GCR_FN_OD_BLINK:
			begin
				pin15_lvl  = BLINK_I ^ mode_q[15]; // see RULE_09
				pin15_oe_n = pin15_lvl;
			end
			// clock only when pin 14 carries the data line
			GCR_FN_TWO_WIRE:
			begin
				pin15_lvl  = ~(TW_SCL_LOW_I && fn14 == GCR_FN_TWO_WIRE);
				pin15_oe_n = pin15_lvl;
			end
			GCR_FN_MODE_OUT:
			begin
				pin15_lvl  = mode_q[15]; // see RULE_07
				pin15_oe_n = pin15_lvl; // open drain, released for high
			end
			default: ;
		endcase
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			PIN14_OUT_O  <= 1'b1;
			PIN14_OE_N_O <= 1'b1;
			PIN15_OUT_O  <= 1'b1;
			PIN15_OE_N_O <= 1'b1;
		end
		else if (CE_I)
		begin
			PIN14_OUT_O  <= pin14_lvl;
			PIN14_OE_N_O <= pin14_oe_n;
			PIN15_OUT_O  <= pin15_oe_n ? 1'b1 : 1'b0;
			PIN15_OE_N_O <= pin15_oe_n;
		end
	end

	// supply selection and two-wire line sensing
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			PIN14_SUPPLY_O <= 1'b0;
			PIN15_SUPPLY_O <= 1'b0;
			TW_SUPPLY_O    <= 1'b0;
			TW_SDA_O       <= 1'b1;
			TW_SCL_O       <= 1'b1;
		end
		else if (CE_I)
		begin
			PIN14_SUPPLY_O <= cfg_q[POS_PIN14_POLARITY_SUPPLY]; // see RULE_02
			PIN15_SUPPLY_O <= cfg_q[POS_PIN15_POLARITY_SUPPLY]; // see RULE_02
			TW_SUPPLY_O    <= cfg_q[POS_PIN14_POLARITY_SUPPLY]; // see RULE_05
			TW_SDA_O       <= g_pin[14].filt_q;
			TW_SCL_O       <= g_pin[15].filt_q;
		end
	end

	// alternate output functions: mode bit chooses the active level
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			SEQ_PIN_O      <= 5'h00;
			FEEDBACK_PIN_O <= 1'b0;
			FAULT_PIN_O    <= 1'b0;
			BLINK11_PIN_O  <= 1'b1;
		end
		else if (CE_I)
		begin
			SEQ_PIN_O <= SEQ_I ^ ~{mode_q[9], mode_q[7], mode_q[6],
				mode_q[4], mode_q[3]}; // see RULE_08
			FEEDBACK_PIN_O <= FEEDBACK_I ^ ~mode_q[13]; // see RULE_10
			FAULT_PIN_O    <= FAULT_I ^ ~mode_q[12]; // see RULE_11
			BLINK11_PIN_O  <= BLINK_I ^ mode_q[11]; // see RULE_09
		end
	end

	// enable inputs carried on pins 8 to 10, debounced per mode bit
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			SYSTEM_ENABLE_INPUT_O  <= 1'b0;
			POWER_ENABLE_INPUT_O  <= 1'b0;
			POWER1_ENABLE_INPUT_O <= 1'b0;
		end
		else if (CE_I)
		begin
			SYSTEM_ENABLE_INPUT_O  <= active[8]; // see RULE_12
			POWER_ENABLE_INPUT_O  <= active[9]; // see RULE_12
			POWER1_ENABLE_INPUT_O <= active[10]; // see RULE_12
		end
	end

	// rail switch control pin selection
	function automatic logic sel_act(input logic [1:0] sel,
		input logic [15:0] act);
		case (sel) // see RULE_18
			GCR_SEL_PIN1:  sel_act = act[1];
			GCR_SEL_PIN2:  sel_act = act[2];
			GCR_SEL_PIN13: sel_act = act[13];
			default:       sel_act = 1'b0;
		endcase
	endfunction

	assign core_act = sel_act(rsw_q[POS_CORE_SWITCH_SEL +: 2], active);
	assign peri_act = sel_act(rsw_q[POS_PERIPHERAL_SWITCH_SEL +: 2], active);

	// edges of the selected pin move the switch request
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			core_act_q <= 1'b0;
			peri_act_q <= 1'b0;
			core_req_q <= 1'b0;
			peri_req_q <= 1'b0;
		end
		else if (CE_I)
		begin
			core_act_q <= core_act;
			peri_act_q <= peri_act;
			if (rsw_q[POS_CORE_SWITCH_SEL +: 2] == GCR_SEL_NONE)
				core_req_q <= 1'b0;
			else if (core_act != core_act_q)
				core_req_q <= core_act; // see RULE_17
			if (rsw_q[POS_PERIPHERAL_SWITCH_SEL +: 2] == GCR_SEL_NONE)
				peri_req_q <= 1'b0;
			else if (peri_act != peri_act_q)
				peri_req_q <= peri_act; // see RULE_16
		end
	end

	// auto pump: runs before a switch closes, stops after the last opens
	assign cp_on = !rsw_q[POS_CHARGE_PUMP_AUTO] || core_req_q ||
		peri_req_q || CORE_RAIL_SWITCH_CLOSE_O || CORE_SWITCH_INTERNAL_CLOSE_O ||
		PERIPHERAL_RAIL_SWITCH_CLOSE_O; // see RULE_13
	assign cp_ready = (cp_cnt_q == CP_CNT_W'(CP_SETTLE_CYCLES));

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			cp_cnt_q <= '0;
		else if (CE_I)
		begin
			if (!cp_on)
				cp_cnt_q <= '0;
			else if (!cp_ready)
				cp_cnt_q <= cp_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			CHARGE_PUMP_EN_O    <= 1'b0;
			CORE_RAIL_SWITCH_CLOSE_O     <= 1'b0;
			CORE_SWITCH_INTERNAL_CLOSE_O <= 1'b0;
			PERIPHERAL_RAIL_SWITCH_CLOSE_O     <= 1'b0;
			SWITCH_SLEW_O       <= 2'h0;
		end
		else if (CE_I)
		begin
			CHARGE_PUMP_EN_O    <= cp_on; // see RULE_13
			CORE_RAIL_SWITCH_CLOSE_O     <= core_req_q & cp_ready &
				~rsw_q[POS_CORE_SWITCH_INTERNAL]; // see RULE_17
			CORE_SWITCH_INTERNAL_CLOSE_O <= core_req_q & cp_ready &
				rsw_q[POS_CORE_SWITCH_INTERNAL]; // see RULE_14
			PERIPHERAL_RAIL_SWITCH_CLOSE_O     <= peri_req_q & cp_ready; // see RULE_16
			SWITCH_SLEW_O       <= rsw_q[POS_SWITCH_CLOSE_SLEW +: 2]; // see RULE_15
		end
	end
endmodule

// >>> test/gcr_props.sv
// concurrent checks on the ports of the gpio and rail switch block
`timescale 1ns/1ps
module gcr_props
	import gcr_pkg::*;
#(
	parameter int DEB_CYCLES = 4
)(
	input wire logic       REF_CLK_I,
	input wire logic       RST_N_I,
	input wire logic       CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic [4:0] SEQ_I,
	input wire logic       FEEDBACK_I,
	input wire logic       PIN14_OUT_O,
	input wire logic       PIN14_OE_N_O,
	input wire logic       PIN15_OE_N_O,
	input wire logic       TW_SUPPLY_O,
	input wire logic [4:0] SEQ_PIN_O,
	input wire logic       FEEDBACK_PIN_O,
	input wire logic       CORE_RAIL_SWITCH_CLOSE_O,
	input wire logic       CORE_SWITCH_INTERNAL_CLOSE_O,
	input wire logic       PERIPHERAL_RAIL_SWITCH_CLOSE_O,
	input wire logic       CHARGE_PUMP_EN_O,
	input wire logic [1:0] SWITCH_SLEW_O
);
	logic [7:0] cfg_q;
	logic [7:0] mlo_q;
	logic [7:0] mhi_q;
	logic [7:0] sw_q;
	logic [1:0] st_cnt_q;
	wire logic [4:0] pol = {mhi_q[1], mlo_q[7], mlo_q[6], mlo_q[4], mlo_q[3]};

	// shadow copies of the written registers, frozen like the block
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			cfg_q <= RST_PINS_14_15_CONFIG;
			mlo_q <= RST_MODE_BITS;
			mhi_q <= RST_MODE_BITS;
			sw_q  <= RST_RAIL_SWITCH;
		end
		else if (WR_I && CE_I)
		begin
			if (ADDR_I == OFS_PINS_14_15_CONFIG)
				cfg_q <= WDATA_I;
			if (ADDR_I == OFS_PINS_0_7_MODE_BITS)
				mlo_q <= WDATA_I;
			if (ADDR_I == OFS_PINS_8_15_MODE_BITS)
				mhi_q <= WDATA_I;
			if (ADDR_I == OFS_RAIL_SWITCH_CONTROL)
				sw_q <= WDATA_I;
		end
	end

	// cycles spent in static pump mode, saturating
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I || sw_q[7])
			st_cnt_q <= 2'h0;
		else if (st_cnt_q != 2'h3)
			st_cnt_q <= st_cnt_q + 2'h1;
	end

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence s_sw_hold;
		$stable(sw_q) [*2];
	endsequence
	sequence s_cfg_hold;
		$stable(cfg_q) [*3];
	endsequence

	chk_rd_idle: assert property (
		!$past(RD_I && CE_I) |-> RDATA_O == 8'h00)
		else $error("read data outside read cycle");
	chk_rd_cfg: assert property (
		RD_I && CE_I && ADDR_I == OFS_PINS_14_15_CONFIG |=> RDATA_O == cfg_q)
		else $error("config read back wrong");
	chk_slew_code: assert property (
		s_sw_hold |-> SWITCH_SLEW_O == sw_q[5:4])
		else $error("slew code differs from field");
	chk_pump_static: assert property (
		st_cnt_q == 2'h3 |-> CHARGE_PUMP_EN_O)
		else $error("pump off in static mode");
	chk_close_pump: assert property (
		CORE_RAIL_SWITCH_CLOSE_O || CORE_SWITCH_INTERNAL_CLOSE_O || PERIPHERAL_RAIL_SWITCH_CLOSE_O
		|-> CHARGE_PUMP_EN_O)
		else $error("switch closed without pump");
	chk_core_excl: assert property (
		CORE_SWITCH_INTERNAL_CLOSE_O |-> !CORE_RAIL_SWITCH_CLOSE_O)
		else $error("internal and external core switch both closed");
	chk_p15_input: assert property (
		(cfg_q[5:4] == 2'h1) [*3] |-> PIN15_OE_N_O)
		else $error("pin 15 driven while input");
	chk_p14_push: assert property (
		(cfg_q[1:0] == 2'h3 && $stable(mhi_q)) [*3]
		|-> !PIN14_OE_N_O && PIN14_OUT_O == mhi_q[6])
		else $error("pin 14 push-pull level wrong");
	chk_tw_supply: assert property (
		s_cfg_hold |-> TW_SUPPLY_O == cfg_q[2])
		else $error("two-wire supply select wrong");
	chk_out_pol: assert property (
		($stable(SEQ_I) && $stable(FEEDBACK_I) && $stable(pol)
		&& $stable(mhi_q[5])) [*3]
		|-> SEQ_PIN_O == ~(SEQ_I ^ pol)
		&& FEEDBACK_PIN_O == (FEEDBACK_I ~^ mhi_q[5]))
		else $error("output polarity wrong");
endmodule

// >>> test/gcr_pin_model.sv
// far side of the pins: external levels, pins 14 and 15 wired-and
`timescale 1ns/1ps
module gcr_pin_model
(
	input  wire logic        clk_i,
	input  wire logic [15:0] lvl_i,
	input  wire logic        p14_out_i,
	input  wire logic        p14_oe_n_i,
	input  wire logic        p15_out_i,
	input  wire logic        p15_oe_n_i,
	output logic      [15:0] gpio_o
);
	initial gpio_o = 16'hC004;
	// a low driven by the block wins over the pulled-up external level
	always @(posedge clk_i)
		gpio_o <= {lvl_i[15] & (p15_oe_n_i | p15_out_i),
			lvl_i[14] & (p14_oe_n_i | p14_out_i), lvl_i[13:0]};
endmodule

// >>> test/tb_gcr_top.sv
// self-checking bench for the gpio and rail switch block
`timescale 1ns/1ps
module tb_gcr_top;
	import gcr_pkg::*;
	localparam int DEB = 4;
	logic        REF_CLK_I = 1'b0;
	logic        RST_N_I = 1'b0;
	logic        CE_I = 1'b1;
	logic [7:0]  ADDR_I = 8'h00;
	logic [7:0]  WDATA_I = 8'h00;
	logic        WR_I = 1'b0;
	logic        RD_I = 1'b0;
	logic [15:0] pins_q = 16'hC004;
	logic [13:0] PIN_ACTIVE_HIGH_I = 14'h3FFB;
	logic [13:0] WAKE_SUPPRESS_I = 14'h0002;
	logic        BLINK_I = 1'b0;
	logic        TW_SDA_LOW_I = 1'b0;
	logic        TW_SCL_LOW_I = 1'b0;
	logic [4:0]  SEQ_I = 5'h00;
	logic        FEEDBACK_I = 1'b0;
	logic        FAULT_I = 1'b0;
	logic [7:0]  RDATA_O;
	logic [15:0] GPIO_I;
	logic [4:0]  SEQ_PIN_O;
	logic [1:0]  SWITCH_SLEW_O;
	logic        IRQ_O, PIN14_OUT_O, PIN14_OE_N_O, PIN15_OUT_O, PIN15_OE_N_O;
	logic        PIN14_SUPPLY_O, PIN15_SUPPLY_O, TW_SUPPLY_O, TW_SDA_O;
	logic        TW_SCL_O, FEEDBACK_PIN_O, FAULT_PIN_O, BLINK11_PIN_O;
	logic        SYSTEM_ENABLE_INPUT_O, POWER_ENABLE_INPUT_O, POWER1_ENABLE_INPUT_O, CORE_RAIL_SWITCH_CLOSE_O;
	logic        CORE_SWITCH_INTERNAL_CLOSE_O, PERIPHERAL_RAIL_SWITCH_CLOSE_O, CHARGE_PUMP_EN_O;
	int          err_count = 0;
	int          comparisons = 0;
	int          n;
	int          pn [4] = '{0, 1, 2, 13};
	// rows: address, write data, expected read back
	logic [23:0] rows [6] = '{24'h1DA5A5, 24'h1E5A5A, 24'h1F3030,
		24'h32C3C3, 24'h40FF00, 24'h1C1111};

	always #25 REF_CLK_I = ~REF_CLK_I;

	gcr_top #(.DEB_CYCLES(DEB)) gcr_top_inst (
		.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
		.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
		.RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .GPIO_I(GPIO_I),
		.PIN_ACTIVE_HIGH_I(PIN_ACTIVE_HIGH_I),
		.WAKE_SUPPRESS_I(WAKE_SUPPRESS_I), .BLINK_I(BLINK_I),
		.TW_SDA_LOW_I(TW_SDA_LOW_I), .TW_SCL_LOW_I(TW_SCL_LOW_I),
		.SEQ_I(SEQ_I), .FEEDBACK_I(FEEDBACK_I), .FAULT_I(FAULT_I),
		.PIN14_OUT_O(PIN14_OUT_O), .PIN14_OE_N_O(PIN14_OE_N_O),
		.PIN15_OUT_O(PIN15_OUT_O), .PIN15_OE_N_O(PIN15_OE_N_O),
		.PIN14_SUPPLY_O(PIN14_SUPPLY_O), .PIN15_SUPPLY_O(PIN15_SUPPLY_O),
		.TW_SUPPLY_O(TW_SUPPLY_O), .TW_SDA_O(TW_SDA_O), .TW_SCL_O(TW_SCL_O),
		.SEQ_PIN_O(SEQ_PIN_O), .FEEDBACK_PIN_O(FEEDBACK_PIN_O),
		.FAULT_PIN_O(FAULT_PIN_O), .BLINK11_PIN_O(BLINK11_PIN_O),
		.SYSTEM_ENABLE_INPUT_O(SYSTEM_ENABLE_INPUT_O), .POWER_ENABLE_INPUT_O(POWER_ENABLE_INPUT_O), .POWER1_ENABLE_INPUT_O(POWER1_ENABLE_INPUT_O),
		.CORE_RAIL_SWITCH_CLOSE_O(CORE_RAIL_SWITCH_CLOSE_O),
		.CORE_SWITCH_INTERNAL_CLOSE_O(CORE_SWITCH_INTERNAL_CLOSE_O),
		.PERIPHERAL_RAIL_SWITCH_CLOSE_O(PERIPHERAL_RAIL_SWITCH_CLOSE_O),
		.CHARGE_PUMP_EN_O(CHARGE_PUMP_EN_O), .SWITCH_SLEW_O(SWITCH_SLEW_O));

	gcr_pin_model gcr_pin_model_inst (.clk_i(REF_CLK_I), .lvl_i(pins_q),
		.p14_out_i(PIN14_OUT_O), .p14_oe_n_i(PIN14_OE_N_O),
		.p15_out_i(PIN15_OUT_O), .p15_oe_n_i(PIN15_OE_N_O), .gpio_o(GPIO_I));

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge REF_CLK_I);
		WR_I <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rd(logic [7:0] a, string nm, logic [7:0] e);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge REF_CLK_I);
		RD_I <= 1'b0;
		#1 chk(nm, e, RDATA_O);
	endtask

	task automatic setp(int i, logic v);
		@(posedge REF_CLK_I);
		pins_q[i] <= v;
	endtask

	function automatic logic obs(int k);
		case (k)
			0: obs = CORE_RAIL_SWITCH_CLOSE_O;
			1: obs = PERIPHERAL_RAIL_SWITCH_CLOSE_O;
			2: obs = CORE_SWITCH_INTERNAL_CLOSE_O;
			3: obs = CHARGE_PUMP_EN_O;
			4: obs = IRQ_O;
			default: obs = SYSTEM_ENABLE_INPUT_O;
		endcase
	endfunction

	// bounded wait for an output level, cycles waited left in n
	task automatic wt(string nm, int k, logic v);
		for (n = 0; n < 80 && obs(k) !== v; n++)
			@(posedge REF_CLK_I) #1;
		chk(nm, {7'h00, v}, {7'h00, obs(k)});
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge REF_CLK_I);
		err_count++;
		complete_run();
	end

	initial
	begin
		repeat (5) @(posedge REF_CLK_I);
		RST_N_I <= 1'b1;
		rd(OFS_PINS_14_15_CONFIG, "cfg rst", 8'h11);
		rd(OFS_RAIL_SWITCH_CONTROL, "sw rst", 8'h00);
		rd(OFS_WAKE_STATUS_LO, "wake rst lo", 8'h00);
		rd(OFS_WAKE_STATUS_HI, "wake rst hi", 8'h00);
		wt("pump static", 3, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], "row", rows[i][7:0]);
		end
		$display("done: register rows");
		wr(OFS_WAKE_STATUS_LO, 8'hFF);
		wr(OFS_WAKE_STATUS_HI, 8'hFF);
		wr(OFS_WAKE_MASK_LO, 8'h01);
		setp(2, 1'b0);
		repeat (12) @(posedge REF_CLK_I);
		rd(OFS_WAKE_STATUS_LO, "wake low", 8'h04);
		chk("irq masked", 8'h00, {7'h00, IRQ_O});
		setp(0, 1'b1);
		setp(1, 1'b1);
		wt("irq", 4, 1'b1);
		rd(OFS_WAKE_STATUS_LO, "wake suppr", 8'h05);
		wr(OFS_WAKE_STATUS_LO, 8'h05);
		wt("irq clear", 4, 1'b0);
		$display("done: wake");
		wr(OFS_PINS_0_7_MODE_BITS, 8'h08);
		setp(3, 1'b1);
		@(posedge REF_CLK_I);
		setp(3, 1'b0);
		repeat (12) @(posedge REF_CLK_I);
		rd(OFS_WAKE_STATUS_LO, "glitch", 8'h00);
		setp(3, 1'b1);
		repeat (16) @(posedge REF_CLK_I);
		rd(OFS_WAKE_STATUS_LO, "debounced", 8'h08);
		$display("done: debounce");
		@(posedge REF_CLK_I);
		PIN_ACTIVE_HIGH_I <= 14'h3FFF;
		pins_q <= 16'hC000;
		setp(8, 1'b1);
		wt("system_enable_input", 5, 1'b1);
		for (int s = 0; s < 2; s++)
			for (int c = 1; c < 4; c++)
			begin
				wr(OFS_RAIL_SWITCH_CONTROL, 8'(c << (2 * s)));
				setp(pn[c], 1'b1);
				wt("sw close", s, 1'b1);
				wt("sw other", 1 - s, 1'b0);
				setp(pn[c], 1'b0);
				wt("sw open", s, 1'b0);
			end
		wr(OFS_RAIL_SWITCH_CONTROL, 8'h81);
		wt("pump idle", 3, 1'b0);
		setp(1, 1'b1);
		wt("pump on", 3, 1'b1);
		wt("core auto", 0, 1'b1);
		chk("settle", 8'h01, 8'(n > CP_SETTLE_CYCLES - 10));
		wr(OFS_RAIL_SWITCH_CONTROL, 8'hC1);
		wt("int close", 2, 1'b1);
		wt("ext open", 0, 1'b0);
		setp(1, 1'b0);
		wt("int open", 2, 1'b0);
		wt("pump stop", 3, 1'b0);
		$display("done: rail switches");
		wr(OFS_PINS_14_15_CONFIG, 8'h33);
		repeat (4) @(posedge REF_CLK_I);
		#1 chk("p14 oe", 8'h00, {7'h00, PIN14_OE_N_O});
		chk("p14 out", 8'h01, {7'h00, PIN14_OUT_O});
		chk("p15 oe", 8'h00, {7'h00, PIN15_OE_N_O});
		chk("p15 out", 8'h00, {7'h00, PIN15_OUT_O});
		wr(OFS_PINS_14_15_CONFIG, 8'h26);
		setp(14, 1'b0);
		repeat (6) @(posedge REF_CLK_I);
		#1 chk("sda", 8'h00, {7'h00, TW_SDA_O});
		chk("tw supply", 8'h01, {7'h00, TW_SUPPLY_O});
		chk("scl", 8'h01, {7'h00, TW_SCL_O});
		chk("p14 supply", 8'h01, {7'h00, PIN14_SUPPLY_O});
		chk("p15 supply", 8'h00, {7'h00, PIN15_SUPPLY_O});
		for (int i = 0; i < 4; i++)
		begin
			@(posedge REF_CLK_I) SEQ_I <= 5'(i * 7);
			FEEDBACK_I <= i[0];
			FAULT_I <= i[1];
			BLINK_I <= i[1];
			repeat (5) @(posedge REF_CLK_I);
			#1 chk("fault", 8'(i[1]), {7'h00, FAULT_PIN_O});
			chk("blink", 8'(!i[1]), {7'h00, BLINK11_PIN_O});
		end
		$display("done: pin functions");
		@(posedge REF_CLK_I) CE_I <= 1'b0;
		wr(OFS_PINS_0_7_MODE_BITS, 8'hFF);
		@(posedge REF_CLK_I) CE_I <= 1'b1;
		rd(OFS_PINS_0_7_MODE_BITS, "ce low", 8'h08);
		@(posedge REF_CLK_I) RST_N_I <= 1'b0;
		repeat (2) @(posedge REF_CLK_I);
		RST_N_I <= 1'b1;
		rd(OFS_PINS_14_15_CONFIG, "cfg rst2", 8'h11);
		rd(OFS_PINS_0_7_MODE_BITS, "mode rst2", 8'h00);
		$display("done: refusal and reset");
		complete_run();
	end
endmodule

bind gcr_top gcr_props #(.DEB_CYCLES(DEB_CYCLES)) gcr_props_inst (
	.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
	.RDATA_O(RDATA_O), .SEQ_I(SEQ_I), .FEEDBACK_I(FEEDBACK_I),
	.PIN14_OUT_O(PIN14_OUT_O), .PIN14_OE_N_O(PIN14_OE_N_O),
	.PIN15_OE_N_O(PIN15_OE_N_O), .TW_SUPPLY_O(TW_SUPPLY_O),
	.SEQ_PIN_O(SEQ_PIN_O), .FEEDBACK_PIN_O(FEEDBACK_PIN_O),
	.CORE_RAIL_SWITCH_CLOSE_O(CORE_RAIL_SWITCH_CLOSE_O),
	.CORE_SWITCH_INTERNAL_CLOSE_O(CORE_SWITCH_INTERNAL_CLOSE_O),
	.PERIPHERAL_RAIL_SWITCH_CLOSE_O(PERIPHERAL_RAIL_SWITCH_CLOSE_O),
	.CHARGE_PUMP_EN_O(CHARGE_PUMP_EN_O), .SWITCH_SLEW_O(SWITCH_SLEW_O));
